// file: design/ofl_defines.vh
// constants for the output frequency limiter
`ifndef OFL_DEFINES_VH
`define OFL_DEFINES_VH

// frequencies are unsigned counts of 0.1 Hz
`define OFL_FW 16

// marker value that switches a jump band off (9999)
`define OFL_OFF_CODE 16'h270f

// range limits
`define OFL_F_0HZ 16'h0000
`define OFL_F_120HZ 16'h04b0
`define OFL_F_400HZ 16'h0fa0

// reset values of the settings
`define OFL_MAX_RST 16'h04b0
`define OFL_MIN_RST 16'h0000
`define OFL_HS_RST 16'h04b0
`define OFL_JOG_RST 16'h0032
`define OFL_START_RST 16'h0005
`define OFL_JUMP_RST 16'h270f

// setting selector codes on the write port
`define OFL_SEL_W 4
`define OFL_SEL_MAX 4'h0
`define OFL_SEL_MIN 4'h1
`define OFL_SEL_HS 4'h2
`define OFL_SEL_JOG 4'h3
`define OFL_SEL_START 4'h4
`define OFL_SEL_JUMP0 4'h5
`define OFL_SEL_LAST 4'ha

// number of jump bands and endpoints
`define OFL_BANDS 3
`define OFL_ENDS 6

`endif

// file: design/ofl_setting_reg.v
// one range-checked frequency setting with a copy path
`default_nettype none

module ofl_setting_reg #(
    parameter [15:0] RST_VAL = 16'h0000,
    parameter [15:0] LO_VAL = 16'h0000,
    parameter [15:0] HI_VAL = 16'h04b0,
    parameter ALLOW_OFF = 0
)
(
    // clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // write side
    input wire wr_in,
    input wire copy_in,
    input wire [15:0] data_in,
    // state
    output reg [15:0] value_out,
    output wire accept_out
);

    `include "ofl_defines.vh"

    // range check, with the off marker where the setting allows it
    wire in_range;
    assign in_range = (data_in >= LO_VAL) && (data_in <= HI_VAL);
    assign accept_out = wr_in && (in_range || ((ALLOW_OFF != 0) && (data_in == `OFL_OFF_CODE)));

    // a direct write is checked; a copy from the twin setting is taken as is
    always @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            value_out <= RST_VAL;
        else if (accept_out || copy_in)
            value_out <= data_in;
    end

endmodule // ofl_setting_reg

`default_nettype wire

// file: design/ofl_jump_band.v
// one frequency jump band: pushes a steady value out of the band
`default_nettype none

module ofl_jump_band (
    // frequency in and out
    input wire [15:0] freq_in,
    output reg [15:0] freq_out,
    // band endpoints, either order
    input wire [15:0] end_a_in,
    input wire [15:0] end_b_in,
    // pass through while ramping
    input wire bypass_in,
    output reg hit_out
);

    `include "ofl_defines.vh"

    reg [15:0] lo;
    reg [15:0] hi;
    reg band_on;

    // either endpoint at the off marker disables the band
    always @*
    begin
        lo = (end_a_in < end_b_in) ? end_a_in : end_b_in;
        hi = (end_a_in < end_b_in) ? end_b_in : end_a_in;
        band_on = (end_a_in != `OFL_OFF_CODE) && (end_b_in != `OFL_OFF_CODE);
        hit_out = 1'b0;
        freq_out = freq_in;
        if (band_on && !bypass_in && (freq_in > lo) && (freq_in < hi))
        begin
            hit_out = 1'b1;
            // nearer endpoint; a tie goes to the lower one, the safer side
            if ((freq_in - lo) <= (hi - freq_in))
                freq_out = lo;
            else
                freq_out = hi;
        end
    end

endmodule // ofl_jump_band

`default_nettype wire

// file: design/ofl_limiter.v
// output frequency limiter: clamps, jog and start handling, jump bands
//
// Summary of operation
// - a command above the maximum is limited to the maximum
// - maximum setting accepts 0 to 120 Hz, resets to 120 Hz
// - below the minimum the output holds at minimum; 0 to 120 Hz, resets 0
// - high-speed maximum accepts 120 to 400 Hz, resets 120 Hz, upper limit
// - writing either maximum copies the value into the other
// - jog at or below minimum is used as is during jog; the code still caps it at the upper limit
// - while stall prevention lowers frequency the lower clamp is not applied
// - start without command runs to minimum when minimum is at least starting
// - three jump bands, endpoints 0 to 400 Hz, 9999 disables a band
// - while ramping the frequency may pass through a jump band
`default_nettype none

module ofl_limiter (
    // clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // setting write port
    input wire param_wr_in,
    input wire [3:0] param_sel_in,
    input wire [15:0] param_data_in,
    // command source
    input wire [15:0] freq_cmd_in,
    input wire cmd_present_in,
    input wire start_in,
    input wire jog_in,
    // acceleration/deceleration stage status
    input wire ramping_in,
    input wire stall_lower_in,
    // limited frequency to the ramp stage
    output reg [15:0] target_freq_out,
    output reg running_out,
    // status
    output reg clamp_high_out,
    output reg clamp_low_out,
    output reg jog_used_out,
    output reg jump_hit_out,
    // setting readback and write result
    output reg [15:0] max_freq_setting_out,
    output reg [15:0] min_freq_setting_out,
    output reg [15:0] high_speed_max_setting_out,
    output reg param_ack_out,
    output reg param_err_out
);

    `include "ofl_defines.vh"

    // selector decode, used for every setting
    function sel_hit;
        input [3:0] sel;
        input [3:0] code;
        begin
            sel_hit = param_wr_in && (sel == code);
        end
    endfunction

    wire [15:0] max_freq_setting;
    wire [15:0] min_freq_setting;
    wire [15:0] high_speed_max_setting;
    wire [15:0] jog_freq_setting;
    wire [15:0] starting_freq_setting;
    wire [95:0] jump_band_endpoints;
    wire max_ok;
    wire min_ok;
    wire hs_ok;
    wire jog_ok;
    wire start_ok;
    wire [5:0] jump_ok;

    // normal maximum; a good high-speed write lands here too
    ofl_setting_reg #(
        .RST_VAL(`OFL_MAX_RST),
        .LO_VAL(`OFL_F_0HZ),
        .HI_VAL(`OFL_F_120HZ),
        .ALLOW_OFF(0)
    ) u_max (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(sel_hit(param_sel_in, `OFL_SEL_MAX)),
        .copy_in(hs_ok),
        .data_in(param_data_in),
        .value_out(max_freq_setting),
        .accept_out(max_ok)
    );

    // minimum
    ofl_setting_reg #(
        .RST_VAL(`OFL_MIN_RST),
        .LO_VAL(`OFL_F_0HZ),
        .HI_VAL(`OFL_F_120HZ),
        .ALLOW_OFF(0)
    ) u_min (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(sel_hit(param_sel_in, `OFL_SEL_MIN)),
        .copy_in(1'b0),
        .data_in(param_data_in),
        .value_out(min_freq_setting),
        .accept_out(min_ok)
    );

    // high-speed maximum; a good normal-maximum write lands here too
    ofl_setting_reg #(
        .RST_VAL(`OFL_HS_RST),
        .LO_VAL(`OFL_F_120HZ),
        .HI_VAL(`OFL_F_400HZ),
        .ALLOW_OFF(0)
    ) u_hs (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(sel_hit(param_sel_in, `OFL_SEL_HS)),
        .copy_in(max_ok),
        .data_in(param_data_in),
        .value_out(high_speed_max_setting),
        .accept_out(hs_ok)
    );

    // jog frequency
    ofl_setting_reg #(
        .RST_VAL(`OFL_JOG_RST),
        .LO_VAL(`OFL_F_0HZ),
        .HI_VAL(`OFL_F_400HZ),
        .ALLOW_OFF(0)
    ) u_jog (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(sel_hit(param_sel_in, `OFL_SEL_JOG)),
        .copy_in(1'b0),
        .data_in(param_data_in),
        .value_out(jog_freq_setting),
        .accept_out(jog_ok)
    );

    // starting frequency
    ofl_setting_reg #(
        .RST_VAL(`OFL_START_RST),
        .LO_VAL(`OFL_F_0HZ),
        .HI_VAL(`OFL_F_400HZ),
        .ALLOW_OFF(0)
    ) u_start (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(sel_hit(param_sel_in, `OFL_SEL_START)),
        .copy_in(1'b0),
        .data_in(param_data_in),
        .value_out(starting_freq_setting),
        .accept_out(start_ok)
    );

    // six jump endpoints, selectors in a row from the first one
    genvar gi;
    generate
        for (gi = 0; gi < `OFL_ENDS; gi = gi + 1)
        begin : g_end
            ofl_setting_reg #(
                .RST_VAL(`OFL_JUMP_RST),
                .LO_VAL(`OFL_F_0HZ),
                .HI_VAL(`OFL_F_400HZ),
                .ALLOW_OFF(1)
            ) u_end (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .wr_in(sel_hit(param_sel_in, `OFL_SEL_JUMP0 + gi[3:0])),
                .copy_in(1'b0),
                .data_in(param_data_in),
                .value_out(jump_band_endpoints[gi*16 +: 16]),
                .accept_out(jump_ok[gi])
            );
        end
    endgenerate

    // source selection and clamping
    reg [15:0] upper_lim;
    reg [15:0] src_freq;
    reg [15:0] clamped;
    reg run_req;
    reg hi_c;
    reg lo_c;
    reg jog_u;

    always @*
    begin
        // the two maxima track each other; above 120 Hz the high-speed one rules
        if (high_speed_max_setting > `OFL_F_120HZ)
            upper_lim = high_speed_max_setting;
        else
            upper_lim = max_freq_setting;
        run_req = start_in || jog_in;
        jog_u = 1'b0;
        hi_c = 1'b0;
        lo_c = 1'b0;
        if (jog_in)
            src_freq = jog_freq_setting;
        else if (start_in && cmd_present_in)
            src_freq = freq_cmd_in;
        else
            src_freq = `OFL_F_0HZ;
        clamped = src_freq;
        if (!run_req)
            clamped = `OFL_F_0HZ;
        else if (jog_in && (jog_freq_setting <= min_freq_setting))
        begin
            // jog below the minimum has precedence
            jog_u = 1'b1;
            if (jog_freq_setting > upper_lim)
            begin
                clamped = upper_lim;
                hi_c = 1'b1;
            end
        end
        else
        begin
            if (src_freq > upper_lim)
            begin
                clamped = upper_lim;
                hi_c = 1'b1;
            end
            else if (!cmd_present_in && !jog_in && (min_freq_setting < starting_freq_setting))
                clamped = `OFL_F_0HZ;
            else if ((src_freq < min_freq_setting) && !stall_lower_in)
            begin
                // start alone also lands here and runs up to the minimum
                clamped = min_freq_setting;
                lo_c = 1'b1;
            end
            // a minimum above the maximum is capped by the maximum
            if (clamped > upper_lim)
                clamped = upper_lim;
        end
    end

    // jump bands in series; bypassed while the ramp stage is moving
    wire [63:0] band_chain;
    wire [2:0] band_hit;
    assign band_chain[15:0] = clamped;

    generate
        for (gi = 0; gi < `OFL_BANDS; gi = gi + 1)
        begin : g_band
            ofl_jump_band u_band (
                .freq_in(band_chain[gi*16 +: 16]),
                .freq_out(band_chain[(gi+1)*16 +: 16]),
                .end_a_in(jump_band_endpoints[gi*32 +: 16]),
                .end_b_in(jump_band_endpoints[gi*32+16 +: 16]),
                .bypass_in(ramping_in),
                .hit_out(band_hit[gi])
            );
        end
    endgenerate

    // registered outputs: one cycle from inputs to target
    always @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            target_freq_out <= 16'h0000;
            running_out <= 1'b0;
            clamp_high_out <= 1'b0;
            clamp_low_out <= 1'b0;
            jog_used_out <= 1'b0;
            jump_hit_out <= 1'b0;
        end
        else
        begin
            target_freq_out <= band_chain[63:48];
            running_out <= run_req;
            clamp_high_out <= hi_c;
            clamp_low_out <= lo_c;
            jog_used_out <= jog_u;
            jump_hit_out <= |band_hit;
        end
    end

    // write result and setting readback, also registered
    wire any_ok;
    wire sel_valid;
    assign any_ok = max_ok | min_ok | hs_ok | jog_ok | start_ok | (|jump_ok);
    assign sel_valid = param_sel_in <= `OFL_SEL_LAST;

    always @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            param_ack_out <= 1'b0;
            param_err_out <= 1'b0;
            max_freq_setting_out <= `OFL_MAX_RST;
            min_freq_setting_out <= `OFL_MIN_RST;
            high_speed_max_setting_out <= `OFL_HS_RST;
        end
        else
        begin
            // out-of-range or unknown selector leaves every setting alone
            param_ack_out <= any_ok;
            param_err_out <= param_wr_in && !(any_ok && sel_valid);
            // mirror the next setting value so readback stands together with ack
            max_freq_setting_out <= (max_ok || hs_ok) ? param_data_in : max_freq_setting;
            min_freq_setting_out <= min_ok ? param_data_in : min_freq_setting;
            high_speed_max_setting_out <= (hs_ok || max_ok) ? param_data_in : high_speed_max_setting;
        end
    end

endmodule // ofl_limiter

`default_nettype wire

// file: test/ofl_ramp_model.sv
// ramp stage model that follows the limited target frequency
`default_nettype none

module ofl_ramp_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // target from the limiter, ramp hold from the bench
    input wire logic [15:0] target_in,
    input wire logic hold_in,
    // running frequency and ramp status
    output logic [15:0] cur_out,
    output logic ramping_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // status is bench-held: deriving it from cur would let bands chatter
    assign ramping_out = hold_in;

    // fixed step per cycle, so long moves span many cycles
    always @(posedge core_clk_in or negedge reset_n_in)
        if (!reset_n_in)
            cur_out <= 16'h0000;
        else if (cur_out + 16'h0064 < target_in)
            cur_out <= cur_out + 16'h0064;
        else if (cur_out > target_in + 16'h0064)
            cur_out <= cur_out - 16'h0064;
        else
            cur_out <= target_in;
endmodule // ofl_ramp_model

`default_nettype wire

// file: test/ofl_limiter_asserts.sv
// concurrent checks on the limiter ports
`default_nettype none

module ofl_limiter_chk (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // inputs
    input wire logic param_wr_in,
    input wire logic [3:0] param_sel_in,
    input wire logic [15:0] param_data_in,
    input wire logic [15:0] freq_cmd_in,
    input wire logic cmd_present_in,
    input wire logic start_in,
    input wire logic jog_in,
    input wire logic ramping_in,
    input wire logic stall_lower_in,
    // outputs
    input wire logic [15:0] target_freq_out,
    input wire logic running_out,
    input wire logic clamp_high_out,
    input wire logic jog_used_out,
    input wire logic jump_hit_out,
    input wire logic [15:0] max_freq_setting_out,
    input wire logic [15:0] min_freq_setting_out,
    input wire logic [15:0] high_speed_max_setting_out,
    input wire logic param_ack_out,
    input wire logic param_err_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    // ramping start with the normal maximum as upper limit; bands bypassed
    wire logic run_w = start_in && !jog_in && cmd_present_in && ramping_in && high_speed_max_setting_out <= 16'h04b0;
    wire logic mn_ok = min_freq_setting_out <= max_freq_setting_out;

    a_max_reject: assert property (param_wr_in && param_sel_in == 4'h0 && param_data_in > 16'h04b0
        |=> param_err_out && $stable(max_freq_setting_out)) else $error("bad maximum write kept");
    a_min_reject: assert property (param_wr_in && param_sel_in == 4'h1 && param_data_in > 16'h04b0
        |=> param_err_out && !param_ack_out) else $error("bad minimum write accepted");
    a_hs_reject: assert property (param_wr_in && param_sel_in == 4'h2 && param_data_in < 16'h04b0
        |=> param_err_out) else $error("bad high speed write accepted");
    a_max_copy: assert property (param_wr_in && param_sel_in == 4'h0 && param_data_in <= 16'h04b0
        |=> param_ack_out && max_freq_setting_out == $past(param_data_in)
        && high_speed_max_setting_out == $past(param_data_in)) else $error("maximum not copied");
    a_hs_copy: assert property (param_wr_in && param_sel_in == 4'h2 && param_data_in inside {[16'h04b0:16'h0fa0]}
        |=> max_freq_setting_out == $past(param_data_in)
        && high_speed_max_setting_out == $past(param_data_in)) else $error("high speed not copied");
    a_upper_clamp: assert property (run_w && freq_cmd_in > max_freq_setting_out
        |=> target_freq_out == $past(max_freq_setting_out) && clamp_high_out) else $error("upper clamp missed");
    a_min_hold: assert property (run_w && !stall_lower_in && mn_ok && freq_cmd_in < min_freq_setting_out
        |=> target_freq_out == $past(min_freq_setting_out)) else $error("minimum clamp missed");
    a_stall_pass: assert property (run_w && stall_lower_in && mn_ok && freq_cmd_in < min_freq_setting_out
        |=> target_freq_out == $past(freq_cmd_in)) else $error("stall output clamped");
    a_ramp_pass: assert property (run_w && freq_cmd_in >= min_freq_setting_out && freq_cmd_in <= max_freq_setting_out
        |=> target_freq_out == $past(freq_cmd_in) && !jump_hit_out) else $error("ramp value moved");
    a_run_follow: assert property ((start_in || jog_in) |=> running_out) else $error("run request not followed");
    a_idle_stop: assert property (!start_in && !jog_in |=> !running_out && target_freq_out == 16'h0000) else $error("idle output not zero");

    c_ack: cover property (param_ack_out);
    c_jump: cover property (jump_hit_out);
    c_jog: cover property (jog_used_out && running_out);
endmodule // ofl_limiter_chk

bind ofl_limiter ofl_limiter_chk u_chk (.core_clk_in, .reset_n_in, .param_wr_in, .param_sel_in, .param_data_in,
    .freq_cmd_in, .cmd_present_in, .start_in, .jog_in, .ramping_in, .stall_lower_in, .target_freq_out,
    .running_out, .clamp_high_out, .jog_used_out, .jump_hit_out, .max_freq_setting_out,
    .min_freq_setting_out, .high_speed_max_setting_out, .param_ack_out, .param_err_out);

`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the output frequency limiter
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in = 0, reset_n_in = 0, param_wr_in = 0, cmd_present_in = 0;
    logic start_in = 0, jog_in = 0, stall_lower_in = 0, hold = 0, chk_f = 0;
    logic [3:0] param_sel_in = 0;
    logic [15:0] param_data_in = 0, freq_cmd_in = 0, mx = 16'h04b0, mn = 0, hs = 16'h04b0;
    wire [15:0] target_freq_out, max_freq_setting_out, min_freq_setting_out, high_speed_max_setting_out, cur_w;
    wire ramping_in, running_out, clamp_high_out, clamp_low_out, jog_used_out, jump_hit_out;
    wire param_ack_out, param_err_out;
    logic [49:0] wq[$];
    logic [19:0] fq[$];
    int fails = 0, num_checks = 0, cyc = 0;
    // {sel, data}
    logic [19:0] wt[10] = '{20'h004b1, 20'h00320, 20'h204af, 20'h104b1, 20'h10064,
        20'h30032, 20'hb0000, 20'h50fa1, 20'h501f4, 20'h60258};
    // {cmd, expected, present, start, jog, stall, hold}
    logic [36:0] ft[12] = '{{16'h1388, 16'h0320, 5'h19}, {16'h0032, 16'h0064, 5'h19}, {16'h0032, 16'h0032, 5'h1b},
        {16'h0000, 16'h0064, 5'h08}, {16'h0000, 16'h0032, 5'h04}, {16'h0208, 16'h01f4, 5'h18},
        {16'h0244, 16'h0258, 5'h18}, {16'h0208, 16'h0208, 5'h19}, {16'h0000, 16'h0000, 5'h00},
        {16'h0208, 16'h0208, 5'h18}, {16'h0fa0, 16'h0fa0, 5'h18}, {16'h0000, 16'h0000, 5'h08}};
    // expected {clamp_high, clamp_low, jog_used, jump_hit} per operating point
    logic [3:0] ff[12] = '{4'h8, 4'h4, 4'h0, 4'h4, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    ofl_limiter u_dut (.core_clk_in, .reset_n_in, .param_wr_in, .param_sel_in, .param_data_in, .freq_cmd_in,
        .cmd_present_in, .start_in, .jog_in, .ramping_in, .stall_lower_in, .target_freq_out, .running_out,
        .clamp_high_out, .clamp_low_out, .jog_used_out, .jump_hit_out, .max_freq_setting_out,
        .min_freq_setting_out, .high_speed_max_setting_out, .param_ack_out, .param_err_out);
    ofl_ramp_model u_ramp (.core_clk_in, .reset_n_in, .target_in(target_freq_out), .hold_in(hold),
        .cur_out(cur_w), .ramping_out(ramping_in));

    initial
        forever #10 core_clk_in = ~core_clk_in;

    task finish_test;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [49:0] seen, input logic [49:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // range of each setting; bad selectors are refused
    function automatic logic ok_f(input logic [3:0] s, input logic [15:0] d);
        case (s)
            4'h0, 4'h1: ok_f = d <= 16'h04b0;
            4'h2: ok_f = d >= 16'h04b0 && d <= 16'h0fa0;
            4'h3, 4'h4: ok_f = d <= 16'h0fa0;
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha: ok_f = d <= 16'h0fa0 || d == 16'h270f;
            default: ok_f = 0;
        endcase
    endfunction

    task wr(input logic [3:0] s, input logic [15:0] d);
        logic ok;
        ok = ok_f(s, d);
        // either maximum write lands in both
        if (ok && (s == 4'h0 || s == 4'h2))
        begin
            mx = d;
            hs = d;
        end
        if (ok && s == 4'h1)
            mn = d;
        wq.push_back({ok, !ok, mx, mn, hs});
        @(posedge core_clk_in);
        #1;
        param_wr_in = 1;
        param_sel_in = s;
        param_data_in = d;
        @(posedge core_clk_in);
        #1;
        param_wr_in = 0;
    endtask

    // apply one operating point, wait until the ramp has settled on it
    task rf(input logic [36:0] e, input logic [3:0] f);
        int n;
        n = 0;
        @(posedge core_clk_in);
        #1;
        {freq_cmd_in, cmd_present_in, start_in, jog_in, stall_lower_in, hold} = {e[36:21], e[4:0]};
        fq.push_back({f, e[20:5]});
        repeat (3) @(posedge core_clk_in);
        for (int k = 0; k < 200 && n < 3; k++)
        begin
            @(posedge core_clk_in);
            n = (cur_w === target_freq_out) ? n + 1 : 0;
        end
        #1;
        chk_f = 1;
        @(posedge core_clk_in);
        #1;
        chk_f = 0;
    endtask

    // watcher: each result takes the oldest note
    always @(negedge core_clk_in)
    begin
        if ((param_ack_out | param_err_out) === 1'b1)
            chk({param_ack_out, param_err_out, max_freq_setting_out, min_freq_setting_out,
                high_speed_max_setting_out}, wq.pop_front());
        if (chk_f)
            chk({30'h0, clamp_high_out, clamp_low_out, jog_used_out, jump_hit_out, target_freq_out},
                {30'h0, fq.pop_front()});
    end

    // hang guard
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            finish_test;
        end
    end

    initial
    begin
        void'($urandom(13));
        repeat (16) @(posedge core_clk_in);
        #1;
        reset_n_in = 1;
        @(negedge core_clk_in);
        chk({max_freq_setting_out, min_freq_setting_out, high_speed_max_setting_out}, 48'h04b0_0000_04b0);
        foreach (wt[i])
            wr(wt[i][19:16], wt[i][15:0]);
        for (int i = 0; i < 9; i++)
            rf(ft[i], ff[i]);
        wr(4'h6, 16'h270f);
        rf(ft[9], ff[9]);
        wr(4'h2, 16'h0fa0);
        rf(ft[10], ff[10]);
        // minimum below starting: start alone must not run up to it
        wr(4'h1, 16'h0003);
        rf(ft[11], ff[11]);
        repeat (3)
            wr(4'h2, 16'h04b0 + 16'($urandom % 2801));
        repeat (8)
            wr(4'($urandom), 16'($urandom));
        repeat (3) @(posedge core_clk_in);
        finish_test;
    end
endmodule // testbench

`default_nettype wire
